/* File: hdl/fifo_params.svh */
// Constants for the programmable-flag FIFO and its controller.
// Assumes inclusion by the package and by each design module.
`ifndef FIFO_PARAMS_SVH
`define FIFO_PARAMS_SVH

// Data path and threshold widths, and depth
`define DATA_W 18
`define THR_W 12
`define CMP_W 13
`define DEPTH 64

// Timing at the 50 MHz clock
`define CLK_PERIOD_NS 20
`define REWIND_RECOVERY_NS 20
`define REWIND_RECOVERY_CYC \
  ((`REWIND_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Controller register offsets (byte addresses)
`define AXI_AW 5
`define REG_CTRL 5'h00
`define REG_WDATA 5'h04
`define REG_RCMD 5'h08
`define REG_RDATA 5'h0C
`define REG_STATUS 5'h10
`define REG_REWIND 5'h14

// Control register fields and reset value
`define CTRL_PROG 0
`define CTRL_ASYNC 1
`define CTRL_RESET 2
`define CTRL_NOT_FIRST 3
`define CTRL_DEPTH_EN 4
`define CTRL_W 5
`define CTRL_RESET_VAL 5'h00

// Response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: hdl/fifo_pkg.sv */
// Types shared by the FIFO, its controller and the link interface.
// Assumes fifo_params.svh sits on the include path.
`include "fifo_params.svh"
package fifo_pkg;
  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`THR_W-1:0]  thr_t;
  // Controller sequencing states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WRITE   = 3'b001,
    ST_READ    = 3'b010,
    ST_CAPTURE = 3'b011,
    ST_REWIND  = 3'b100,
    ST_RECOVER = 3'b101
  } ctl_state_t;
endpackage

/* File: hdl/fifo_if.sv */
// Pin-level link between the FIFO device and its controlling logic.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ps
interface fifo_if;
  import fifo_pkg::*;
  // Write side
  logic  wr_en_n;
  word_t data_in;
  logic  prog_select_n;
  // Read side
  logic  rd_en_n;
  word_t data_out;
  // Control
  logic  rewind_pulse;
  logic  master_reset_n;
  logic  sync_flag_sel_n;
  logic  first_dev_sel_n;
  logic  depth_mode_en;
  // Flags
  logic  full_flag_n;
  logic  empty_flag_n;
  logic  almost_empty_n;
  logic  almost_full_n;
  logic  half_full_n;
  // Cascade
  logic  wr_cascade_in_n;
  logic  rd_cascade_in_n;
  logic  wr_cascade_out_n;
  logic  rd_cascade_out_n;

  modport dev (
    input  wr_en_n, data_in, prog_select_n, rd_en_n, rewind_pulse,
    input  master_reset_n, sync_flag_sel_n, first_dev_sel_n,
    input  depth_mode_en, wr_cascade_in_n, rd_cascade_in_n,
    output data_out, full_flag_n, empty_flag_n, almost_empty_n,
    output almost_full_n, half_full_n, wr_cascade_out_n,
    output rd_cascade_out_n
  );
  modport ctl (
    output wr_en_n, data_in, prog_select_n, rd_en_n, rewind_pulse,
    output master_reset_n, sync_flag_sel_n, first_dev_sel_n,
    output depth_mode_en, wr_cascade_in_n, rd_cascade_in_n,
    input  data_out, full_flag_n, empty_flag_n, almost_empty_n,
    input  almost_full_n, half_full_n, wr_cascade_out_n,
    input  rd_cascade_out_n
  );
endinterface

/* File: hdl/sync_fifo_prog_flags.sv */
// FIFO device: 18-bit storage, five flags, threshold registers,
// rewind and depth-cascade tokens.
// Assumes write and read sides share aclk; pins come from same-clock logic.
`timescale 1ns/1ps
`include "fifo_params.svh"
module sync_fifo_prog_flags
  import fifo_pkg::*;
#(
  parameter int DEPTH = `DEPTH
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin link
  fifo_if.dev       link
);
  localparam int AW = $clog2(DEPTH);

  // Default threshold for each supported depth
  function automatic thr_t default_offset(input int depth);
    case (depth)
      64:      default_offset = 12'h007;
      256:     default_offset = 12'h01F;
      512:     default_offset = 12'h03F;
      default: default_offset = 12'h07F;
    endcase
  endfunction

  localparam thr_t EMPTY_DEF = default_offset(DEPTH);
  localparam thr_t FULL_DEF  = default_offset(DEPTH);
  localparam logic [`CMP_W-1:0] DEPTH_CMP = `CMP_W'(DEPTH);
  localparam logic [`CMP_W-1:0] HALF_CMP  = `CMP_W'(DEPTH / 2);
  localparam logic [AW-1:0]     LAST_LOC  = AW'(DEPTH - 1);

  // Storage and state
  word_t          mem [DEPTH];
  logic [AW:0]    wptr;
  logic [AW:0]    rptr;
  thr_t           empty_threshold_reg;
  thr_t           full_threshold_reg;
  logic           wr_sel;
  logic           rd_sel;
  word_t          out_word;
  logic           full_r;
  logic           empty_r;
  logic           ae_r;
  logic           af_r;
  logic           hf_r;
  logic           wr_token;
  logic           rd_token;
  logic           wxo_r;
  logic           rxo_r;

  // Decoded pin requests
  wire rst      = !aresetn || !link.master_reset_n;
  wire prog_wr  = !link.prog_select_n && !link.wr_en_n;
  wire prog_rd  = !link.prog_select_n && !link.rd_en_n;
  wire wr_held  = link.depth_mode_en && !wr_token;
  wire rd_held  = link.depth_mode_en && !rd_token;
  wire wr_ok    = link.prog_select_n && !link.wr_en_n && full_r
                  && !wr_held;
  wire rd_ok    = link.prog_select_n && !link.rd_en_n && empty_r
                  && !rd_held;
  // Rewind is ignored in depth cascades
  wire rewind   = link.rewind_pulse && !link.depth_mode_en;
  wire wr_last  = wr_ok && (wptr[AW-1:0] == LAST_LOC);
  wire rd_last  = rd_ok && (rptr[AW-1:0] == LAST_LOC);

  // Pointer and count arithmetic
  wire [AW:0] next_wptr = wptr + (AW+1)'(wr_ok);
  wire [AW:0] next_rptr = rewind ? '0 : rptr + (AW+1)'(rd_ok);
  wire [AW:0] count     = wptr - rptr;
  wire [AW:0] next_cnt  = next_wptr - next_rptr;
  wire [`CMP_W-1:0] cnt_c  = `CMP_W'(count);
  wire [`CMP_W-1:0] ncnt_c = `CMP_W'(next_cnt);
  wire [`CMP_W-1:0] e_thr  = `CMP_W'(empty_threshold_reg);
  wire [`CMP_W-1:0] f_thr  = `CMP_W'(full_threshold_reg);
  // A full threshold at or beyond depth pins almost-full on
  wire [`CMP_W-1:0] af_lim = (f_thr >= DEPTH_CMP) ? '0
                             : DEPTH_CMP - f_thr;

  // Almost flags, live and next-edge forms
  wire ae_now  = cnt_c <= e_thr;
  wire ae_next = ncnt_c <= e_thr;
  wire af_now  = cnt_c >= af_lim;
  wire af_next = ncnt_c >= af_lim;

  // Storage write; no reset needed on the array
  always_ff @(posedge aclk) begin
    if (wr_ok) begin
      mem[wptr[AW-1:0]] <= link.data_in;
    end
  end

  // Pointers
  always_ff @(posedge aclk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Threshold programming writes
  always_ff @(posedge aclk) begin
    if (rst) begin
      empty_threshold_reg <= EMPTY_DEF;
      full_threshold_reg  <= FULL_DEF;
      wr_sel              <= 1'b0;
    end else if (prog_wr) begin
      if (!wr_sel) begin
        empty_threshold_reg <= link.data_in[`THR_W-1:0];
      end else begin
        full_threshold_reg  <= link.data_in[`THR_W-1:0];
      end
      wr_sel <= !wr_sel;
    end
  end

  // Output word: data reads and threshold reads
  always_ff @(posedge aclk) begin
    if (rst) begin
      out_word <= '0;
      rd_sel   <= 1'b0;
    end else if (prog_rd) begin
      out_word <= `DATA_W'(rd_sel ? full_threshold_reg
                                  : empty_threshold_reg);
      rd_sel   <= !rd_sel;
    end else if (rd_ok) begin
      out_word <= mem[rptr[AW-1:0]];
    end
  end

  // Registered flags, all active low
  always_ff @(posedge aclk) begin
    if (rst) begin
      full_r  <= 1'b1;
      empty_r <= 1'b0;
      ae_r    <= 1'b0;
      af_r    <= 1'b1;
      hf_r    <= 1'b1;
    end else begin
      full_r  <= !(ncnt_c == DEPTH_CMP);
      empty_r <= !(ncnt_c == '0);
      ae_r    <= !ae_next;
      af_r    <= !af_next;
      hf_r    <= !(ncnt_c > HALF_CMP);
    end
  end

  // Cascade tokens: one device at a time owns each side
  always_ff @(posedge aclk) begin
    if (rst) begin
      wr_token <= !link.first_dev_sel_n;
      rd_token <= !link.first_dev_sel_n;
      wxo_r    <= 1'b1;
      rxo_r    <= 1'b1;
    end else begin
      wxo_r <= !(link.depth_mode_en && wr_last);
      rxo_r <= !(link.depth_mode_en && rd_last);
      if (link.depth_mode_en && wr_last) begin
        wr_token <= 1'b0;
      end else if (!link.wr_cascade_in_n) begin
        wr_token <= 1'b1;
      end
      if (link.depth_mode_en && rd_last) begin
        rd_token <= 1'b0;
      end else if (!link.rd_cascade_in_n) begin
        rd_token <= 1'b1;
      end
    end
  end

  // Pin outputs
  assign link.data_out         = out_word;
  assign link.full_flag_n      = full_r;
  assign link.empty_flag_n     = empty_r;
  // Low select gives clocked almost flags, high gives live ones
  assign link.almost_empty_n   = link.sync_flag_sel_n ? !ae_now
                                                      : ae_r;
  assign link.almost_full_n    = link.sync_flag_sel_n ? !af_now
                                                      : af_r;
  assign link.half_full_n      = link.depth_mode_en ? wxo_r
                                                    : hf_r;
  assign link.wr_cascade_out_n = wxo_r;
  assign link.rd_cascade_out_n = rxo_r;
endmodule

/* File: hdl/axil_regs.sv */
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the owner decodes addresses and may stall writes.
`timescale 1ns/1ps
`include "fifo_params.svh"
module axil_regs (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Write channels
  input  wire logic [`AXI_AW-1:0] awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // Read channels
  input  wire logic [`AXI_AW-1:0] araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Owner side
  input  wire logic               wr_ready,
  output logic                    reg_wr,
  output logic [`AXI_AW-1:0]      reg_waddr,
  output logic [31:0]             reg_wdata,
  output logic [3:0]              reg_wstrb,
  input  wire logic               wr_err,
  output logic [`AXI_AW-1:0]      reg_raddr,
  input  wire logic [31:0]        reg_rdata,
  input  wire logic               rd_err
);
  logic aw_held;
  logic w_held;

  // Handshake decode
  assign awready   = !aw_held && !bvalid;
  assign wready    = !w_held && !bvalid;
  assign arready   = !rvalid;
  assign reg_wr    = aw_held && w_held && wr_ready;
  assign reg_raddr = araddr;

  // Write address and data capture, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      reg_waddr <= '0;
      reg_wdata <= '0;
      reg_wstrb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        reg_waddr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held    <= 1'b1;
        reg_wdata <= wdata;
        reg_wstrb <= wstrb;
      end
      if (reg_wr) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= reg_rdata;
      rresp  <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

/* File: hdl/fifo_controller.sv */
// Controlling end: turns register commands into FIFO pin cycles.
// Assumes a single device whose cascade outputs loop to its inputs.
`timescale 1ns/1ps
`include "fifo_params.svh"
module fifo_controller
  import fifo_pkg::*;
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write channels
  input  wire logic [`AXI_AW-1:0] awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // AXI4-Lite read channels
  input  wire logic [`AXI_AW-1:0] araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Pin link
  fifo_if.ctl                     link
);
  localparam logic [3:0] RECOVER_CYC = 4'(`REWIND_RECOVERY_CYC);

  ctl_state_t              state;
  logic [`CTRL_W-1:0]      ctrl;
  word_t                   rd_word;
  logic [3:0]              wait_cnt;
  logic                    wr_en_r;
  logic                    rd_en_r;
  logic                    rewind_r;
  word_t                   data_r;
  logic                    reg_wr;
  logic [`AXI_AW-1:0]      reg_waddr;
  logic [31:0]             reg_wdata;
  logic [3:0]              reg_wstrb;
  logic [`AXI_AW-1:0]      reg_raddr;
  logic [31:0]             reg_rdata;

  // Register decode
  wire idle      = state == ST_IDLE;
  wire in_reset  = ctrl[`CTRL_RESET];
  wire hit_ctrl  = reg_wr && reg_waddr == `REG_CTRL && reg_wstrb[0];
  wire hit_wdata = reg_wr && reg_waddr == `REG_WDATA && !in_reset;
  wire hit_rcmd  = reg_wr && reg_waddr == `REG_RCMD && !in_reset;
  wire hit_rew   = reg_wr && reg_waddr == `REG_REWIND && !in_reset
                   && !ctrl[`CTRL_DEPTH_EN];
  wire wr_err    = !(reg_waddr == `REG_CTRL || reg_waddr == `REG_WDATA
                   || reg_waddr == `REG_RCMD
                   || reg_waddr == `REG_REWIND);
  wire rd_err    = !(reg_raddr == `REG_CTRL || reg_raddr == `REG_RDATA
                   || reg_raddr == `REG_STATUS);
  // One device only, so its flags are the composite flags
  wire [31:0] status = {26'h000_0000, !idle, link.half_full_n,
                        link.almost_full_n, link.almost_empty_n,
                        link.full_flag_n, link.empty_flag_n};
  assign reg_rdata = (reg_raddr == `REG_CTRL)   ? 32'(ctrl)
                   : (reg_raddr == `REG_RDATA)  ? 32'(rd_word)
                   : (reg_raddr == `REG_STATUS) ? status
                   : 32'h0000_0000;

  axil_regs i_axil_regs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready   (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready    (wready),
    .bresp     (bresp),
    .bvalid    (bvalid),
    .bready    (bready),
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready   (arready),
    .rdata     (rdata),
    .rresp     (rresp),
    .rvalid    (rvalid),
    .rready    (rready),
    .wr_ready  (idle),
    .reg_wr    (reg_wr),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb),
    .wr_err    (wr_err),
    .reg_raddr (reg_raddr),
    .reg_rdata (reg_rdata),
    .rd_err    (rd_err)
  );

  // Pin sequencer: each command is one enable cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      ctrl     <= `CTRL_RESET_VAL;
      wr_en_r  <= 1'b1;
      rd_en_r  <= 1'b1;
      rewind_r <= 1'b0;
      data_r   <= '0;
      rd_word  <= '0;
      wait_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (hit_ctrl) begin
            ctrl <= reg_wdata[`CTRL_W-1:0];
          end
          if (hit_wdata) begin
            data_r  <= reg_wdata[`DATA_W-1:0];
            wr_en_r <= 1'b0;
            state   <= ST_WRITE;
          end else if (hit_rcmd) begin
            rd_en_r <= 1'b0;
            state   <= ST_READ;
          end else if (hit_rew) begin
            rewind_r <= 1'b1;
            state    <= ST_REWIND;
          end
        end
        ST_WRITE: begin
          wr_en_r <= 1'b1;
          state   <= ST_IDLE;
        end
        ST_READ: begin
          rd_en_r <= 1'b1;
          state   <= ST_CAPTURE;
        end
        ST_CAPTURE: begin
          rd_word <= link.data_out;
          state   <= ST_IDLE;
        end
        ST_REWIND: begin
          rewind_r <= 1'b0;
          wait_cnt <= RECOVER_CYC;
          state    <= ST_RECOVER;
        end
        ST_RECOVER: begin
          if (wait_cnt <= 4'h1) begin
            state <= ST_IDLE;
          end
          wait_cnt <= wait_cnt - 4'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pin drive
  assign link.wr_en_n         = wr_en_r;
  assign link.rd_en_n         = rd_en_r;
  assign link.data_in         = data_r;
  assign link.rewind_pulse    = rewind_r;
  assign link.prog_select_n   = !ctrl[`CTRL_PROG];
  assign link.master_reset_n  = !in_reset;
  assign link.sync_flag_sel_n = ctrl[`CTRL_ASYNC];
  assign link.first_dev_sel_n = ctrl[`CTRL_NOT_FIRST];
  assign link.depth_mode_en   = ctrl[`CTRL_DEPTH_EN];
  assign link.wr_cascade_in_n = link.wr_cascade_out_n;
  assign link.rd_cascade_in_n = link.rd_cascade_out_n;
endmodule

/* File: test/sync_fifo_prog_flags_props.sv */
// Checker for the pin link between the FIFO and its controller.
// Assumes one aclk domain and synchronous active-low aresetn.
`timescale 1ns/1ps
module sync_fifo_prog_flags_props
  import fifo_pkg::*;
(
  // Clock and reset
  input wire logic  aclk,
  input wire logic  aresetn,
  // Link inputs of the device
  input wire logic  wr_en_n,
  input wire logic  prog_select_n,
  input wire logic  rd_en_n,
  input wire logic  rewind_pulse,
  input wire logic  master_reset_n,
  input wire logic  depth_mode_en,
  // Link outputs of the device
  input wire word_t data_out,
  input wire logic  full_flag_n,
  input wire logic  empty_flag_n,
  input wire logic  almost_empty_n,
  input wire logic  almost_full_n,
  input wire logic  half_full_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Flag relations, blocking of refused transfers, master reset and idle pins around rewind
  a_write_sets_data: assert property (prog_select_n && !wr_en_n &&
    master_reset_n |=> empty_flag_n) else $error("write left flag empty");
  a_empty_almost: assert property (!empty_flag_n |->
    !almost_empty_n) else $error("empty without almost empty");
  a_full_flags: assert property (!full_flag_n && !depth_mode_en |->
    !almost_full_n && !half_full_n) else $error("full without af, hf");
  a_half_nonempty: assert property (!half_full_n &&
    !depth_mode_en |-> empty_flag_n) else $error("half full when empty");
  a_full_blocks: assert property (!full_flag_n && rd_en_n &&
    master_reset_n |=> !full_flag_n) else $error("full flag left");
  a_empty_holds: assert property (!empty_flag_n && wr_en_n &&
    prog_select_n && master_reset_n && !rewind_pulse |=> !empty_flag_n &&
    $stable(data_out)) else $error("empty read changed output");
  a_prog_no_store: assert property (!prog_select_n &&
    !empty_flag_n && master_reset_n && !rewind_pulse |=> !empty_flag_n)
    else $error("threshold write stored a word");
  a_reset_empties: assert property (!master_reset_n |=>
    !empty_flag_n && full_flag_n && half_full_n)
    else $error("master reset did not empty");
  a_rewind_idle: assert property (rewind_pulse |->
    wr_en_n && rd_en_n ##1 wr_en_n && rd_en_n && !rewind_pulse)
    else $error("transfer around rewind");
endmodule

/* File: test/sync_fifo_prog_flags_bench.sv */
// Bench: controller and FIFO joined by the link, driven over AXI4-Lite.
// Assumes the design files and fifo_params.svh are compiled first.
`timescale 1ns/1ps
`include "fifo_params.svh"
module sync_fifo_prog_flags_bench
  import fifo_pkg::*;
;
  typedef struct packed {
    logic              w;
    logic [`AXI_AW-1:0] a;
    logic [31:0]       d;
    logic [1:0]        r;
  } row_t;
  logic               aclk, aresetn, awvalid, awready, wvalid, wready;
  logic               bvalid, bready, arvalid, arready, rvalid, rready;
  logic [`AXI_AW-1:0] awaddr, araddr;
  logic [31:0]        wdata, rdata, v;
  logic [1:0]         bresp, rresp;
  int                 error_cnt, samples_checked, et, ft;
  row_t               rows [15];

  fifo_if link_if();
  sync_fifo_prog_flags i_sync_fifo_prog_flags (.aclk(aclk),
    .aresetn(aresetn), .link(link_if));
  fifo_controller i_fifo_controller (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link(link_if));
  sync_fifo_prog_flags_props i_sync_fifo_prog_flags_props (.aclk(aclk),
    .aresetn(aresetn), .wr_en_n(link_if.wr_en_n),
    .prog_select_n(link_if.prog_select_n), .rd_en_n(link_if.rd_en_n),
    .rewind_pulse(link_if.rewind_pulse),
    .master_reset_n(link_if.master_reset_n),
    .depth_mode_en(link_if.depth_mode_en), .data_out(link_if.data_out),
    .full_flag_n(link_if.full_flag_n), .empty_flag_n(link_if.empty_flag_n),
    .almost_empty_n(link_if.almost_empty_n),
    .almost_full_n(link_if.almost_full_n),
    .half_full_n(link_if.half_full_n));

  // Clock at 50 MHz
  always #10 aclk = ~aclk;

  task automatic stop_test;
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Write address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    chk("rresp", 32'(er), 32'(rresp));
    repeat (2) @(posedge aclk);
  endtask

  // Status bits expected for a word count c
  task automatic stchk(input int c);
    logic [31:0] e;
    e = {26'h0, 1'b0, c <= `DEPTH / 2, c < `DEPTH - ft, c > et,
         c != `DEPTH, c != 0};
    rd(`REG_STATUS, `RESP_OKAY, v);
    chk("status", e, v & 32'h3F);
  endtask

  // Pop one word through the controller and compare it
  task automatic pop(input int e);
    wr(`REG_RCMD, 32'h0, `RESP_OKAY);
    rd(`REG_RDATA, `RESP_OKAY, v);
    chk("rdata", 32'(e), v);
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    stop_test;
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, error_cnt, samples_checked} = '0;
    rows = '{'{1, `REG_CTRL, 32'h1, 0}, '{1, `REG_WDATA, 32'h5, 0},
      '{1, `REG_CTRL, 32'h0, 0}, '{1, `REG_CTRL, 32'h1, 0},
      '{1, `REG_WDATA, 32'h28, 0}, '{1, `REG_RCMD, 32'h0, 0},
      '{0, `REG_RDATA, 32'h5, 0}, '{1, `REG_RCMD, 32'h0, 0},
      '{0, `REG_RDATA, 32'h28, 0}, '{1, `REG_RCMD, 32'h0, 0},
      '{0, `REG_RDATA, 32'h5, 0}, '{1, `REG_WDATA, 32'h0002_3005, 0},
      '{1, `REG_CTRL, 32'h0, 0}, '{1, 5'h18, 32'h0, 2},
      '{0, 5'h18, 32'h0, 2}};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    et = 7;
    ft = 7;
    stchk(0);
    // Threshold programming, readback order and unmapped access
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
      else begin
        rd(rows[i].a, rows[i].r, v);
        chk("row", rows[i].d, v);
      end
    end
    et = 5;
    ft = 40;
    // Fill past full, then drain past empty
    for (int i = 1; i <= 65; i++) begin
      wr(`REG_WDATA, 32'(i * 3), `RESP_OKAY);
      stchk(i > 64 ? 64 : i);
    end
    for (int i = 1; i <= 65; i++) begin
      pop((i > 64 ? 64 : i) * 3);
      stchk(i > 64 ? 0 : 64 - i);
    end
    // Master reset restores default thresholds
    wr(`REG_CTRL, 32'h4, `RESP_OKAY);
    wr(`REG_CTRL, 32'h3, `RESP_OKAY);
    et = 7;
    ft = 7;
    for (int i = 0; i < 2; i++) pop(7);
    wr(`REG_CTRL, 32'h2, `RESP_OKAY);
    stchk(0);
    // Rewind replays words already read, async flag mode
    for (int i = 1; i <= 3; i++) wr(`REG_WDATA, 32'(i + 9), `RESP_OKAY);
    pop(10);
    pop(11);
    stchk(1);
    wr(`REG_REWIND, 32'h0, `RESP_OKAY);
    stchk(3);
    for (int i = 1; i <= 3; i++) pop(i + 9);
    stchk(0);
    // Depth mode: half-full pin carries the cascade, rewind ignored
    wr(`REG_CTRL, 32'h10, `RESP_OKAY);
    for (int i = 1; i <= 33; i++) wr(`REG_WDATA, 32'(i + 20), `RESP_OKAY);
    rd(`REG_STATUS, `RESP_OKAY, v);
    chk("cascade_hf", 32'h1, 32'(v[4]));
    wr(`REG_REWIND, 32'h0, `RESP_OKAY);
    pop(21);
    stop_test;
  end
endmodule
